// [hw/exvec_regs.svh]
// constants for exception vector and space code logic
`ifndef EXVEC_REGS_SVH
`define EXVEC_REGS_SVH
`define EXV_FC_USER_DATA 3'h1
`define EXV_FC_USER_PROG 3'h2
`define EXV_FC_SUP_DATA 3'h5
`define EXV_FC_SUP_PROG 3'h6
`define EXV_FC_CPU 3'h7
`define EXV_RESET_SP_ADDR 32'h00000000
`define EXV_RESET_PC_ADDR 32'h00000004
`define EXV_VEC_BUS_ERR 8'h02
`define EXV_VEC_ADDR_ERR 8'h03
`define EXV_VEC_ILLEGAL 8'h04
`define EXV_VEC_ZERO_DIV 8'h05
`define EXV_VEC_BOUND 8'h06
`define EXV_VEC_COND_TRAP 8'h07
`define EXV_VEC_PRIV 8'h08
`define EXV_VEC_TRACE 8'h09
`define EXV_VEC_LINE_A 8'h0A
`define EXV_VEC_LINE_F 8'h0B
`define EXV_VEC_CP_PROTO 8'h0D
`define EXV_VEC_FORMAT 8'h0E
`define EXV_VEC_UNINIT 8'h0F
`define EXV_VEC_SPURIOUS 8'h18
`define EXV_VEC_AUTO_BASE 8'h18
`define EXV_VEC_TRAP_BASE 8'h20
`define EXV_CPU_TYPE_IACK 4'hF
`define EXV_SR_RESET 16'h2700
`define EXV_SR_S_BIT 13
`define EXV_SR_T1_BIT 15
`define EXV_SR_T0_BIT 14
`define EXV_FMT_SHORT 4'h0
`define EXV_FMT_LONG 4'h2
`define EXV_FRAME_SHORT_BYTES 8'h08
`define EXV_FRAME_LONG_BYTES 8'h0C
`endif

// [hw/exvec_pkg.sv]
// types for exception vector and space code logic
package exvec_pkg;
  // access kinds requested by the core
  typedef enum logic [2:0] {
    EXVEC_ACC_DATA = 3'h0,
    EXVEC_ACC_PROG = 3'h1,
    EXVEC_ACC_CPU_FN = 3'h2,
    EXVEC_ACC_ALT = 3'h3
  } exvec_acc_t;
  // exception causes presented by the core
  typedef enum logic [3:0] {
    EXVEC_CAUSE_BUS_ERR = 4'h0,
    EXVEC_CAUSE_ADDR_ERR = 4'h1,
    EXVEC_CAUSE_ILLEGAL = 4'h2,
    EXVEC_CAUSE_ZERO_DIV = 4'h3,
    EXVEC_CAUSE_BOUND = 4'h4,
    EXVEC_CAUSE_COND_TRAP = 4'h5,
    EXVEC_CAUSE_PRIV = 4'h6,
    EXVEC_CAUSE_TRACE = 4'h7,
    EXVEC_CAUSE_LINE_A = 4'h8,
    EXVEC_CAUSE_LINE_F = 4'h9,
    EXVEC_CAUSE_CP_PROTO = 4'hA,
    EXVEC_CAUSE_FORMAT = 4'hB,
    EXVEC_CAUSE_UNINIT = 4'hC,
    EXVEC_CAUSE_TRAP = 4'hD,
    EXVEC_CAUSE_INTR = 4'hE,
    EXVEC_CAUSE_EXT = 4'hF
  } exvec_cause_t;
  typedef enum logic [2:0] {
    EXVEC_ST_IDLE = 3'h0,
    EXVEC_ST_STATUS = 3'h1,
    EXVEC_ST_VECTOR = 3'h3,
    EXVEC_ST_SAVE = 3'h2,
    EXVEC_ST_LOAD = 3'h6,
    EXVEC_ST_RST_SP = 3'h7,
    EXVEC_ST_RST_PC = 3'h5,
    EXVEC_ST_DONE = 3'h4
  } exvec_state_t;
endpackage

// [hw/exvec_space_code.sv]
// space code encoder for ordinary bus cycles
`timescale 1ns/100ps
`include "exvec_regs.svh"
module exvec_space_code (
  // request
  input wire logic sup_level,
  input wire exvec_pkg::exvec_acc_t kind,
  input wire logic [2:0] alt_code,
  // result
  output logic [2:0] code
);
  always_comb begin
    case (kind)
      exvec_pkg::EXVEC_ACC_DATA: begin
        code = sup_level ? `EXV_FC_SUP_DATA : `EXV_FC_USER_DATA;
      end
      exvec_pkg::EXVEC_ACC_PROG: begin
        code = sup_level ? `EXV_FC_SUP_PROG : `EXV_FC_USER_PROG;
      end
      exvec_pkg::EXVEC_ACC_CPU_FN: begin
        code = `EXV_FC_CPU;
      end
      exvec_pkg::EXVEC_ACC_ALT: begin
        code = alt_code;
      end
      default: begin
        code = `EXV_FC_USER_DATA;
      end
    endcase
  end
endmodule

// [hw/exvec_unit.sv]
// exception vector, stack frame and space code unit
`timescale 1ns/100ps
`include "exvec_regs.svh"
module exvec_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // ordinary bus cycle classification
  input wire logic cyc_req,
  input wire exvec_pkg::exvec_acc_t cyc_kind,
  input wire logic [2:0] alt_space,
  // exception request
  input wire logic exc_req,
  input wire exvec_pkg::exvec_cause_t exc_cause,
  input wire logic [3:0] exc_index,
  input wire logic [7:0] exc_ext_vector,
  input wire logic [3:0] exc_format,
  input wire logic [31:0] exc_pc,
  input wire logic reset_seq,
  // status and vector base
  input wire logic [15:0] sr_in,
  input wire logic sr_load,
  input wire logic [31:0] vbr_in,
  input wire logic vbr_load,
  // exception bus read
  output logic ex_rd,
  output logic [31:0] ex_addr,
  input wire logic ex_ack,
  input wire logic [31:0] ex_rdata,
  // interrupt acknowledge data
  input wire logic [7:0] iack_vector,
  // space code outputs
  output logic [2:0] space_code_outputs,
  // status and results
  output logic [15:0] sr_out,
  output logic [15:0] sr_saved,
  output logic [31:0] vbr_out,
  output logic [31:0] frame_pc,
  output logic [15:0] frame_fmt_offset,
  output logic frame_valid,
  output logic [31:0] new_pc,
  output logic [31:0] new_isp,
  output logic exc_busy,
  output logic exc_done,
  // return from exception decode
  input wire logic [3:0] return_from_exception,
  output logic [7:0] rte_release_bytes,
  output logic rte_long_restore
);
  exvec_pkg::exvec_state_t state_q;
  exvec_pkg::exvec_state_t state_d;
  logic [15:0] sr_q;
  logic [15:0] sr_tmp_q;
  logic [31:0] vbr_q;
  logic [7:0] vec_q;
  logic [7:0] vec_int;
  logic [31:0] vec_addr;
  logic [31:0] frame_pc_q;
  logic [15:0] frame_fo_q;
  logic frame_valid_q;
  logic [31:0] new_pc_q;
  logic [31:0] new_isp_q;
  logic done_q;
  logic rd_q;
  logic [31:0] addr_q;
  logic [2:0] exc_code;
  logic [2:0] cyc_code;
  logic is_intr;
  logic [3:0] fmt_q;
  logic [31:0] pc_q;
  logic iack_pend_q;

  assign is_intr = (exc_cause == exvec_pkg::EXVEC_CAUSE_INTR);

  // internal vector numbers
  always_comb begin
    case (exc_cause)
      exvec_pkg::EXVEC_CAUSE_BUS_ERR: begin
        vec_int = `EXV_VEC_BUS_ERR;
      end
      exvec_pkg::EXVEC_CAUSE_ADDR_ERR: begin
        vec_int = `EXV_VEC_ADDR_ERR;
      end
      exvec_pkg::EXVEC_CAUSE_ILLEGAL: begin
        vec_int = `EXV_VEC_ILLEGAL;
      end
      exvec_pkg::EXVEC_CAUSE_ZERO_DIV: begin
        vec_int = `EXV_VEC_ZERO_DIV;
      end
      exvec_pkg::EXVEC_CAUSE_BOUND: begin
        vec_int = `EXV_VEC_BOUND;
      end
      exvec_pkg::EXVEC_CAUSE_COND_TRAP: begin
        vec_int = `EXV_VEC_COND_TRAP;
      end
      exvec_pkg::EXVEC_CAUSE_PRIV: begin
        vec_int = `EXV_VEC_PRIV;
      end
      exvec_pkg::EXVEC_CAUSE_TRACE: begin
        vec_int = `EXV_VEC_TRACE;
      end
      exvec_pkg::EXVEC_CAUSE_LINE_A: begin
        vec_int = `EXV_VEC_LINE_A;
      end
      exvec_pkg::EXVEC_CAUSE_LINE_F: begin
        vec_int = `EXV_VEC_LINE_F;
      end
      exvec_pkg::EXVEC_CAUSE_CP_PROTO: begin
        vec_int = `EXV_VEC_CP_PROTO;
      end
      exvec_pkg::EXVEC_CAUSE_FORMAT: begin
        vec_int = `EXV_VEC_FORMAT;
      end
      exvec_pkg::EXVEC_CAUSE_UNINIT: begin
        vec_int = `EXV_VEC_UNINIT;
      end
      exvec_pkg::EXVEC_CAUSE_TRAP: begin
        vec_int = `EXV_VEC_TRAP_BASE + {4'h0, exc_index};
      end
      exvec_pkg::EXVEC_CAUSE_INTR: begin
        // index 0 is spurious, 1 to 7 are the autovector levels
        vec_int = `EXV_VEC_AUTO_BASE + {5'h00, exc_index[2:0]};
      end
      default: vec_int = exc_ext_vector;
    endcase
  end

  // any number, reserved or not, scales the same way
  assign vec_addr = vbr_q + {22'h000000, vec_q, 2'h0};

  // exception sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      exvec_pkg::EXVEC_ST_IDLE: begin
        if (reset_seq) begin
          state_d = exvec_pkg::EXVEC_ST_RST_SP;
        end else if (exc_req) begin
          state_d = exvec_pkg::EXVEC_ST_STATUS;
        end
      end
      exvec_pkg::EXVEC_ST_STATUS: state_d = exvec_pkg::EXVEC_ST_VECTOR;
      exvec_pkg::EXVEC_ST_VECTOR: begin
        if (!iack_pend_q || ex_ack) begin
          state_d = exvec_pkg::EXVEC_ST_SAVE;
        end
      end
      exvec_pkg::EXVEC_ST_SAVE: state_d = exvec_pkg::EXVEC_ST_LOAD;
      exvec_pkg::EXVEC_ST_LOAD: begin
        if (ex_ack) begin
          state_d = exvec_pkg::EXVEC_ST_DONE;
        end
      end
      exvec_pkg::EXVEC_ST_RST_SP: begin
        if (ex_ack) begin
          state_d = exvec_pkg::EXVEC_ST_RST_PC;
        end
      end
      exvec_pkg::EXVEC_ST_RST_PC: begin
        if (ex_ack) begin
          state_d = exvec_pkg::EXVEC_ST_DONE;
        end
      end
      exvec_pkg::EXVEC_ST_DONE: state_d = exvec_pkg::EXVEC_ST_IDLE;
      default: state_d = exvec_pkg::EXVEC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= exvec_pkg::EXVEC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // status register with step one setup
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sr_q <= `EXV_SR_RESET;
      sr_tmp_q <= `EXV_SR_RESET;
    end else if (state_q == exvec_pkg::EXVEC_ST_IDLE && exc_req &&
                 !reset_seq) begin
      sr_tmp_q <= sr_q;
      sr_q[`EXV_SR_S_BIT] <= 1'b1;
      sr_q[`EXV_SR_T1_BIT] <= 1'b0;
      sr_q[`EXV_SR_T0_BIT] <= 1'b0;
    end else if (state_q == exvec_pkg::EXVEC_ST_IDLE && reset_seq) begin
      // reset runs step one too, but keeps no saved copy
      sr_q[`EXV_SR_S_BIT] <= 1'b1;
      sr_q[`EXV_SR_T1_BIT] <= 1'b0;
      sr_q[`EXV_SR_T0_BIT] <= 1'b0;
    end else if (state_q == exvec_pkg::EXVEC_ST_IDLE && sr_load) begin
      sr_q <= sr_in;
    end
  end

  // vector base; a reset sequence points the table back at zero
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      vbr_q <= 32'h00000000;
    end else if (state_q == exvec_pkg::EXVEC_ST_IDLE && reset_seq) begin
      vbr_q <= 32'h00000000;
    end else if (state_q == exvec_pkg::EXVEC_ST_IDLE && vbr_load) begin
      vbr_q <= vbr_in;
    end
  end

  // vector number: internal, supplied, or by acknowledge read
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      vec_q <= 8'h00;
      iack_pend_q <= 1'b0;
    end else if (state_q == exvec_pkg::EXVEC_ST_IDLE && exc_req) begin
      vec_q <= vec_int;
      // an interrupt without autovector index reads the number
      iack_pend_q <= is_intr && exc_index == 4'hF;
    end else if (state_q == exvec_pkg::EXVEC_ST_VECTOR && iack_pend_q &&
                 ex_ack) begin
      vec_q <= iack_vector;
      iack_pend_q <= 1'b0;
    end
  end

  // request fields held: the core may move on once the request is taken
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fmt_q <= 4'h0;
      pc_q <= 32'h00000000;
    end else if (state_q == exvec_pkg::EXVEC_ST_IDLE && exc_req) begin
      fmt_q <= exc_format;
      pc_q <= exc_pc;
    end
  end

  // stack frame header
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      frame_pc_q <= 32'h00000000;
      frame_fo_q <= 16'h0000;
      frame_valid_q <= 1'b0;
    end else if (state_q == exvec_pkg::EXVEC_ST_SAVE) begin
      frame_pc_q <= pc_q;
      frame_fo_q <= {fmt_q, 2'h0, vec_q, 2'h0};
      frame_valid_q <= 1'b1;
    end else begin
      frame_valid_q <= 1'b0;
    end
  end

  // exception bus reads
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_q <= 1'b0;
      addr_q <= 32'h00000000;
    end else begin
      case (state_d)
        exvec_pkg::EXVEC_ST_RST_SP: begin
          rd_q <= 1'b1;
          addr_q <= `EXV_RESET_SP_ADDR;
        end
        exvec_pkg::EXVEC_ST_RST_PC: begin
          rd_q <= 1'b1;
          addr_q <= `EXV_RESET_PC_ADDR;
        end
        exvec_pkg::EXVEC_ST_VECTOR: begin
          rd_q <= iack_pend_q || (state_q == exvec_pkg::EXVEC_ST_STATUS &&
                  is_intr && exc_index == 4'hF);
          addr_q <= {28'h0000000, `EXV_CPU_TYPE_IACK};
        end
        exvec_pkg::EXVEC_ST_LOAD: begin
          rd_q <= 1'b1;
          addr_q <= vec_addr;
        end
        default: begin
          rd_q <= 1'b0;
        end
      endcase
    end
  end

  // loaded context
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      new_pc_q <= 32'h00000000;
      new_isp_q <= 32'h00000000;
      done_q <= 1'b0;
    end else begin
      done_q <= state_d == exvec_pkg::EXVEC_ST_DONE;
      if (ex_ack && state_q == exvec_pkg::EXVEC_ST_RST_SP) begin
        new_isp_q <= ex_rdata;
      end
      if (ex_ack && (state_q == exvec_pkg::EXVEC_ST_RST_PC ||
                     state_q == exvec_pkg::EXVEC_ST_LOAD)) begin
        new_pc_q <= ex_rdata;
      end
    end
  end

  // space code of exception reads, from the next state so that it
  // changes at the same edge as the read request it classifies
  always_comb begin
    case (state_d)
      exvec_pkg::EXVEC_ST_RST_SP: exc_code = `EXV_FC_SUP_PROG;
      exvec_pkg::EXVEC_ST_RST_PC: exc_code = `EXV_FC_SUP_PROG;
      exvec_pkg::EXVEC_ST_VECTOR: exc_code = `EXV_FC_CPU;
      default: exc_code = `EXV_FC_SUP_DATA;
    endcase
  end

  exvec_space_code u_space (
    .sup_level(sr_q[`EXV_SR_S_BIT]),
    .kind(cyc_kind),
    .alt_code(alt_space),
    .code(cyc_code)
  );

  // only the codes above leave; no location is fixed beyond reset
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      space_code_outputs <= `EXV_FC_SUP_PROG;
    end else if (state_d != exvec_pkg::EXVEC_ST_IDLE) begin
      space_code_outputs <= exc_code;
    end else if (cyc_req) begin
      space_code_outputs <= cyc_code;
    end
  end

  // frame format decode; unknown formats release the short frame
  always_comb begin
    rte_long_restore = (return_from_exception == `EXV_FMT_LONG);
    rte_release_bytes = rte_long_restore ? `EXV_FRAME_LONG_BYTES :
                        `EXV_FRAME_SHORT_BYTES;
  end

  assign ex_rd = rd_q;
  assign ex_addr = addr_q;
  assign sr_out = sr_q;
  assign sr_saved = sr_tmp_q;
  assign vbr_out = vbr_q;
  assign frame_pc = frame_pc_q;
  assign frame_fmt_offset = frame_fo_q;
  assign frame_valid = frame_valid_q;
  assign new_pc = new_pc_q;
  assign new_isp = new_isp_q;
  assign exc_busy = state_q != exvec_pkg::EXVEC_ST_IDLE;
  assign exc_done = done_q;
endmodule

// [dv/exvec_asserts.sv]
// port property checker for the exception vector unit
`timescale 1ns/100ps
module exvec_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // requests
  input wire logic cyc_req,
  input wire exvec_pkg::exvec_acc_t cyc_kind,
  input wire logic exc_req,
  input wire logic reset_seq,
  input wire logic sr_load,
  input wire logic ex_ack,
  input wire logic [3:0] return_from_exception,
  // results
  input wire logic ex_rd,
  input wire logic [31:0] ex_addr,
  input wire logic [2:0] space_code_outputs,
  input wire logic [15:0] sr_out,
  input wire logic [31:0] vbr_out,
  input wire logic [15:0] frame_fmt_offset,
  input wire logic frame_valid,
  input wire logic exc_busy,
  input wire logic exc_done,
  input wire logic [7:0] rte_release_bytes,
  input wire logic rte_long_restore
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  logic plain;
  // status must be stable for the level check to mean anything
  assign plain = cyc_req && !exc_busy && !exc_req && !reset_seq && !sr_load;

  a_code_never_reserved: assert property (
    space_code_outputs != 3'h0 && space_code_outputs != 3'h3 &&
    space_code_outputs != 3'h4) else $error("reserved space code");
  a_data_code_level: assert property (
    plain && cyc_kind == exvec_pkg::EXVEC_ACC_DATA |=>
    space_code_outputs == ($past(sr_out[13]) ? 3'h5 : 3'h1))
    else $error("data space code wrong");
  a_prog_code_level: assert property (
    plain && cyc_kind == exvec_pkg::EXVEC_ACC_PROG |=>
    space_code_outputs == ($past(sr_out[13]) ? 3'h6 : 3'h2))
    else $error("program space code wrong");
  a_cpu_fn_code: assert property (
    plain && cyc_kind == exvec_pkg::EXVEC_ACC_CPU_FN |=>
    space_code_outputs == 3'h7) else $error("cpu space code wrong");
  a_vec_addr_sum: assert property (
    frame_valid |-> ex_addr == vbr_out + {22'h0, frame_fmt_offset[9:0]})
    else $error("vector address wrong");
  a_vec_space_sd: assert property (
    frame_valid |-> ex_rd && space_code_outputs == 3'h5)
    else $error("vector fetch space wrong");
  a_status_step_one: assert property (
    $rose(exc_busy) |=> sr_out[13] && sr_out[15:14] == 2'b00)
    else $error("status not prepared");
  a_iack_type_f: assert property (
    ex_rd && space_code_outputs == 3'h7 |-> ex_addr == 32'h0000000F)
    else $error("acknowledge read type wrong");
  a_reset_word_order: assert property (
    ex_ack && ex_rd && space_code_outputs == 3'h6 && ex_addr == 32'h0 |=>
    ##[0:2] (ex_rd && ex_addr == 32'h4 && space_code_outputs == 3'h6))
    else $error("second reset word missing");
  a_done_after_read: assert property (
    exc_done |-> $past(ex_ack) || $past(ex_ack, 2) || $past(ex_ack, 3))
    else $error("done without final read");
  a_rte_decode: assert property (
    rte_long_restore == (return_from_exception == 4'h2) &&
    rte_release_bytes == (rte_long_restore ? 8'h0C : 8'h08))
    else $error("frame release decode wrong");

  c_vec_read: cover property (frame_valid);
  c_iack_read: cover property (ex_ack && space_code_outputs == 3'h7);
  c_reset_read: cover property (ex_ack && space_code_outputs == 3'h6);
  c_done: cover property (exc_done);
endmodule

bind exvec_unit exvec_asserts u_exvec_asserts (
  .clk_sys, .rst_b, .cyc_req, .cyc_kind, .exc_req, .reset_seq, .sr_load,
  .ex_ack, .return_from_exception, .ex_rd, .ex_addr, .space_code_outputs,
  .sr_out, .vbr_out, .frame_fmt_offset, .frame_valid, .exc_busy,
  .exc_done, .rte_release_bytes, .rte_long_restore
);

// [dv/exvec_mem_model.sv]
// memory and acknowledge responder on the exception read port
`timescale 1ns/100ps
module exvec_mem_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // read request
  input wire logic ex_rd,
  input wire logic [31:0] ex_addr,
  input wire logic [2:0] space_code_outputs,
  // answer pacing and acknowledge number
  input wire logic [3:0] dly,
  input wire logic [7:0] iack_set,
  // answer
  output logic ex_ack,
  output logic [31:0] ex_rdata,
  output logic [7:0] iack_vector
);
  logic [3:0] cnt_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ex_ack <= 1'b0;
      cnt_q <= 4'h0;
      ex_rdata <= 32'h0;
      iack_vector <= 8'h0;
    end else if (ex_ack || !ex_rd || cnt_q != dly) begin
      // toggled so stale data never looks valid
      ex_ack <= 1'b0;
      ex_rdata <= ~ex_rdata;
      iack_vector <= ~iack_vector;
      cnt_q <= (ex_ack || !ex_rd) ? 4'h0 : cnt_q + 4'h1;
    end else begin
      ex_ack <= 1'b1;
      // word tied to its address
      ex_rdata <= {ex_addr[15:0], ~ex_addr[15:0]};
      // any number returned, unfiltered
      iack_vector <= (space_code_outputs == 3'h7) ? iack_set : ~iack_vector;
    end
  end
endmodule

// [dv/tb_top.sv]
// self-checking bench for the exception vector unit
`timescale 1ns/100ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cyc_req = 1'b0;
  exvec_pkg::exvec_acc_t cyc_kind = exvec_pkg::EXVEC_ACC_DATA;
  exvec_pkg::exvec_cause_t exc_cause = exvec_pkg::EXVEC_CAUSE_BUS_ERR;
  logic [2:0] alt_space = 3'h0;
  logic exc_req = 1'b0;
  logic reset_seq = 1'b0;
  logic sr_load = 1'b0;
  logic vbr_load = 1'b0;
  logic [3:0] exc_index = 4'h0;
  logic [3:0] exc_format = 4'h0;
  logic [3:0] return_from_exception = 4'h0;
  logic [3:0] dly = 4'h0;
  logic [7:0] exc_ext_vector = 8'h00;
  logic [7:0] iack_set = 8'h00;
  logic [15:0] sr_in = 16'h0000;
  logic [31:0] exc_pc = 32'h0;
  logic [31:0] vbr_in = 32'h0;
  logic ex_rd, ex_ack, frame_valid, exc_busy, exc_done, rte_long_restore;
  logic [2:0] space_code_outputs, code_q;
  logic [7:0] iack_vector, rte_release_bytes, eb;
  logic [15:0] sr_out, sr_saved, frame_fmt_offset, fo_q, sr_b;
  logic [31:0] ex_addr, ex_rdata, vbr_out, frame_pc, new_pc, new_isp;
  logic [31:0] fpc_q, vb;
  int err_count = 0;
  int checks = 0;

  exvec_unit u_exvec_unit (
    .clk_sys, .rst_b, .cyc_req, .cyc_kind, .alt_space, .exc_req,
    .exc_cause, .exc_index, .exc_ext_vector, .exc_format, .exc_pc,
    .reset_seq, .sr_in, .sr_load, .vbr_in, .vbr_load, .ex_rd, .ex_addr,
    .ex_ack, .ex_rdata, .iack_vector, .space_code_outputs, .sr_out,
    .sr_saved, .vbr_out, .frame_pc, .frame_fmt_offset, .frame_valid,
    .new_pc, .new_isp, .exc_busy, .exc_done, .return_from_exception,
    .rte_release_bytes, .rte_long_restore
  );
  exvec_mem_model u_exvec_mem_model (
    .clk_sys, .rst_b, .ex_rd, .ex_addr, .space_code_outputs, .dly,
    .iack_set, .ex_ack, .ex_rdata, .iack_vector
  );

  always #20 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (frame_valid === 1'b1) begin
      fo_q <= frame_fmt_offset;
      fpc_q <= frame_pc;
    end
    if (ex_ack === 1'b1 && ex_rd === 1'b1) begin
      code_q <= space_code_outputs;
    end
  end

  function automatic logic [31:0] word_at(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction

  task automatic results();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (exc_done !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    chk(n < 100, "no completion");
  endtask

  task automatic ld(input logic [15:0] s, input logic [31:0] v);
    // loads are refused until the unit is back in idle
    while (exc_busy === 1'b1) begin
      tick();
    end
    sr_in = s;
    vbr_in = v;
    sr_load = 1'b1;
    vbr_load = 1'b1;
    tick();
    sr_load = 1'b0;
    vbr_load = 1'b0;
    chk(sr_out === s && vbr_out === v, "status or base load");
  endtask

  // caller lowers cyc_req after a run of classifications
  task automatic cls(input logic [2:0] k, input logic [2:0] a,
                     input logic [2:0] e);
    cyc_kind = exvec_pkg::exvec_acc_t'(k);
    alt_space = a;
    cyc_req = 1'b1;
    tick();
    chk(space_code_outputs === e, "space code");
  endtask

  task automatic exc(input logic [3:0] c, input logic [3:0] x,
                     input logic [7:0] e, input logic [7:0] v);
    // a request in the done cycle would be dropped
    while (exc_busy === 1'b1) begin
      tick();
    end
    sr_b = sr_out;
    vb = vbr_out;
    exc_cause = exvec_pkg::exvec_cause_t'(c);
    exc_index = x;
    exc_ext_vector = e;
    exc_format = {2'b00, v[0], 1'b0};
    exc_pc = {v, 24'h123456};
    exc_req = 1'b1;
    tick();
    exc_req = 1'b0;
    // a base load while busy must be dropped
    vbr_in = 32'h0BAD0000;
    vbr_load = 1'b1;
    tick();
    vbr_load = 1'b0;
    wait_done();
    chk(new_pc === word_at(vb + {22'h0, v, 2'b00}), "vector addr");
    chk(fo_q === {exc_format, 2'b00, v, 2'b00}, "frame header");
    chk(fpc_q === exc_pc && code_q === 3'h5, "frame pc or space");
    chk(sr_saved === sr_b && sr_out[15:13] === 3'h1, "status");
    chk(vbr_out === vb, "base changed while busy");
  endtask

  // 41 exceptions of at most 30 cycles each, with margin
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    results();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    chk(space_code_outputs === 3'h6 && sr_out === 16'h2700, "reset");
    ld(16'h2000, 32'h00001000);
    reset_seq = 1'b1;
    tick();
    reset_seq = 1'b0;
    wait_done();
    chk(new_isp === word_at(32'h0), "stack word");
    chk(new_pc === word_at(32'h4), "pc word");
    chk(vbr_out === 32'h0 && code_q === 3'h6, "reset space");
    cls(3'h0, 3'h0, 3'h5);
    cls(3'h1, 3'h0, 3'h6);
    cls(3'h2, 3'h0, 3'h7);
    cls(3'h3, 3'h7, 3'h7);
    cyc_req = 1'b0;
    ld(16'h0000, 32'h00001000);
    cls(3'h0, 3'h0, 3'h1);
    cls(3'h1, 3'h0, 3'h2);
    cls(3'h2, 3'h0, 3'h7);
    cls(3'h3, 3'h1, 3'h1);
    cyc_req = 1'b0;
    // user mode with both trace bits set
    ld(16'hC000, 32'h00001000);
    for (int i = 0; i < 13; i++) begin
      dly = i[3:0];
      exc(i[3:0], 4'h0, 8'h00, (i < 10) ? 8'(i + 2) : 8'(i + 3));
    end
    for (int i = 0; i < 16; i++) begin
      dly = {2'b00, i[1:0]};
      exc(4'hD, i[3:0], 8'h00, 8'(i + 32));
    end
    for (int i = 0; i < 8; i++) begin
      exc(4'hE, i[3:0], 8'h00, 8'(i + 24));
    end
    dly = 4'h9;
    iack_set = 8'h05;
    exc(4'hE, 4'hF, 8'h00, 8'h05);
    iack_set = 8'hC8;
    exc(4'hE, 4'hF, 8'h00, 8'hC8);
    exc(4'hF, 4'h0, 8'h0C, 8'h0C);
    ld(16'h2000, 32'hFFFFFF00);
    exc(4'hF, 4'h0, 8'hFF, 8'hFF);
    for (int f = 0; f < 4; f++) begin
      return_from_exception = f[3:0];
      eb = (f == 2) ? 8'h0C : 8'h08;
      tick();
      chk(rte_release_bytes === eb, "release size");
      chk(rte_long_restore === (f == 2), "restore kind");
    end
    results();
  end
endmodule
